// File: rtl/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_TIMER_SEL   = 8'h00;
	localparam logic [7:0] OFS_SHUTDOWN    = 8'h04;
	localparam logic [7:0] OFS_RESTART_DLY = 8'h08;
	localparam logic [7:0] OFS_STEERING    = 8'h0c;
	localparam logic [7:0] OFS_CHANNEL     = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SD_STATUS_BIT   = 7;
	localparam int SD_SRC_HI       = 6;
	localparam int SD_SRC_LO       = 4;
	localparam int SD_AC_HI        = 3;
	localparam int SD_AC_LO        = 2;
	localparam int SD_BD_HI        = 1;
	localparam int SD_BD_LO        = 0;
	localparam int RESTART_BIT     = 7;
	localparam int DELAY_HI        = 6;
	localparam int STEER_SYNC_BIT  = 4;
	localparam int CH_CFG_HI       = 7;
	localparam int CH_CFG_LO       = 6;
	localparam int CH_CSYNC_BIT    = 4;
	localparam int CH_MODE_HI      = 3;
	localparam int IRQ_SHUT_BIT    = 0;
	localparam int IRQ_RESTART_BIT = 1;
	localparam int IRQ_STEER_BIT   = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TIMER_SEL   = 8'h00;
	localparam logic [7:0] RST_SHUTDOWN    = 8'h00;
	localparam logic [7:0] RST_RESTART_DLY = 8'h00;
	localparam logic [7:0] RST_STEERING    = 8'h01;
	localparam logic [7:0] RST_CHANNEL     = 8'h00;
	localparam logic [2:0] RST_IRQ         = 3'h0;

	// ------------------------------------------------------------
	// codes and timing
	// ------------------------------------------------------------
	localparam logic [1:0] TB_TIMER2      = 2'h0;
	localparam logic [1:0] TB_TIMER4      = 2'h1;
	localparam logic [1:0] TB_TIMER6      = 2'h2;
	localparam logic [1:0] MODE_PWM_HI    = 2'h3;
	localparam logic [1:0] CFG_SINGLE     = 2'h0;
	localparam logic [1:0] CFG_FULL_FWD   = 2'h1;
	localparam logic [1:0] CFG_HALF       = 2'h2;
	localparam logic [1:0] CFG_FULL_REV   = 2'h3;
	localparam logic [1:0] SAFE_LOW       = 2'h0;
	localparam logic [1:0] SAFE_HIGH      = 2'h1;
	localparam logic [1:0] CYC_DIV_LAST   = 2'h3;
	localparam int         DELAY_W        = 7;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pin_bus_t;

	typedef struct packed {
		logic cmp1;
		logic cmp2;
		logic int_pin;
	} trip_in_t;

endpackage

// File: rtl/deadband_delay.sv
`timescale 1ns/10ps
module deadband_delay (
	input  wire logic                              clk_sys,
	input  wire logic                              srst,
	input  wire logic                              cyc_en,
	input  wire logic [pwm_ctrl_pkg::DELAY_W-1:0] delay,
	input  wire logic                              din,
	output logic                                   dout
);
	logic [pwm_ctrl_pkg::DELAY_W-1:0] cnt_q;
	logic                             din_q;

	// ------------------------------------------------------------
	// active-going edge held back, inactive edge passes at once
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_q <= '0;
			din_q <= 1'b0;
			dout  <= 1'b0;
		end else begin
			din_q <= din;
			if (!din) begin
				dout  <= 1'b0;
				cnt_q <= '0;
			end else if (!din_q) begin
				cnt_q <= delay;
				dout  <= (delay == '0);
			end else if (cnt_q != '0) begin
				// counted in instruction cycles, not in clocks
				if (cyc_en) begin
					cnt_q <= cnt_q - 1'b1;
					dout  <= (cnt_q == 7'h01);
				end
			end else begin
				dout <= 1'b1;
			end
		end
	end
endmodule

// File: rtl/pwm_shutdown_steering_ctrl.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
// Functional notes
// - timebase from timer2, timer4 or timer6
// - source select picks shutdown trip conditions
// - pair safe states: low, high, tristate
// - comparator trips wait for timer1 sync edge
// - auto restart clears status when trip gone
// - without restart, software clears shutdown status
// - half-bridge active edges delayed by dead-band cycle count
// - steering update at period start or cycle
// - steer bits route polarised pwm or port
// - steering only in pwm single-output mode
// - low mode bits set pair polarity
// - half-bridge: complementary a/b with dead band
module pwm_shutdown_steering_ctrl (
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic [2:0]             timer_pwm,
	input  wire logic [2:0]             timer_period_start,
	input  wire logic                   timer1_sync,
	input  wire pwm_ctrl_pkg::trip_in_t trip_async,
	input  wire logic [3:0]             port_out,
	input  wire logic [3:0]             port_oe,
	output pwm_ctrl_pkg::pin_bus_t      pwm_pins,
	output logic                        irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [1:0] ch5_timebase_select;
	logic [7:0] shutdown_ctl_q;
	logic       shutdown_status;
	logic [7:0] restart_dly_q;
	logic [4:0] steer_shadow_q;
	logic [3:0] steer_live_q;
	logic [7:0] channel_q;
	logic [2:0] irq_status_q;
	logic [2:0] irq_mask_q;

	logic       wr_en;
	logic       rd_ack;
	logic [1:0] cyc_div_q;
	logic       cyc_en;

	logic [2:0] cmp1_sync_q;
	logic [2:0] cmp2_sync_q;
	logic [2:0] int_sync_q;
	logic       cmp1_f_q;
	logic       cmp2_f_q;
	logic       int_f_q;
	logic       cmp1_trip_q;
	logic       cmp2_trip_q;
	logic       cmp1_trip;
	logic       cmp2_trip;
	logic       trip;

	logic       pwm_sel;
	logic       period_sel;
	logic       pwm_mode;
	logic       steer_ok;
	logic [1:0] out_cfg;
	logic       pol_ac_low;
	logic       pol_bd_low;
	logic       db_a;
	logic       db_b;
	logic [3:0] drv_out;
	logic [3:0] drv_oe;
	logic       sd_rise;
	logic       auto_clear;
	logic       steer_apply;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] safe_drive(input logic [1:0] st);
		// returns {oe, out}; code 1x floats the pair
		case (st)
			pwm_ctrl_pkg::SAFE_LOW:  safe_drive = 2'h2;
			pwm_ctrl_pkg::SAFE_HIGH: safe_drive = 2'h3;
			default:                 safe_drive = 2'h0;
		endcase
	endfunction

	function automatic logic polar(input logic level, input logic low_act);
		polar = level ^ low_act;
	endfunction

	// ------------------------------------------------------------
	// instruction cycle enable, one clock in four
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cyc_div_q <= 2'h0;
		end else begin
			cyc_div_q <= cyc_div_q + 2'h1;
		end
	end
	assign cyc_en = (cyc_div_q == pwm_ctrl_pkg::CYC_DIV_LAST);

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	// one wait state; unmapped addresses ack and read zero
	assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign rd_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign shutdown_status = shutdown_ctl_q[pwm_ctrl_pkg::SD_STATUS_BIT];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= rd_ack;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_ack) begin
			case (wb_adr_i)
				pwm_ctrl_pkg::OFS_TIMER_SEL:   wb_dat_o <= {30'h0, ch5_timebase_select};
				pwm_ctrl_pkg::OFS_SHUTDOWN:    wb_dat_o <= {24'h0, shutdown_ctl_q};
				pwm_ctrl_pkg::OFS_RESTART_DLY: wb_dat_o <= {24'h0, restart_dly_q};
				pwm_ctrl_pkg::OFS_STEERING:    wb_dat_o <= {27'h0, steer_shadow_q};
				pwm_ctrl_pkg::OFS_CHANNEL:     wb_dat_o <= {24'h0, channel_q};
				pwm_ctrl_pkg::OFS_IRQ_STATUS:  wb_dat_o <= {29'h0, irq_status_q};
				pwm_ctrl_pkg::OFS_IRQ_MASK:    wb_dat_o <= {29'h0, irq_mask_q};
				default:                       wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ch5_timebase_select <= pwm_ctrl_pkg::RST_TIMER_SEL[1:0];
			restart_dly_q       <= pwm_ctrl_pkg::RST_RESTART_DLY;
			channel_q           <= pwm_ctrl_pkg::RST_CHANNEL;
			steer_shadow_q      <= pwm_ctrl_pkg::RST_STEERING[4:0];
			irq_mask_q          <= pwm_ctrl_pkg::RST_IRQ;
		end else if (wr_en) begin
			case (wb_adr_i)
				pwm_ctrl_pkg::OFS_TIMER_SEL:   ch5_timebase_select <= wb_dat_i[1:0];
				pwm_ctrl_pkg::OFS_RESTART_DLY: restart_dly_q       <= wb_dat_i[7:0];
				pwm_ctrl_pkg::OFS_CHANNEL:     channel_q           <= wb_dat_i[7:0];
				pwm_ctrl_pkg::OFS_STEERING:    steer_shadow_q      <= wb_dat_i[4:0];
				pwm_ctrl_pkg::OFS_IRQ_MASK:    irq_mask_q          <= wb_dat_i[2:0];
				default:                       irq_mask_q          <= irq_mask_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// trip input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cmp1_sync_q <= 3'h0;
			cmp2_sync_q <= 3'h0;
			int_sync_q  <= 3'h7;
			cmp1_f_q    <= 1'b0;
			cmp2_f_q    <= 1'b0;
			int_f_q     <= 1'b1;
		end else begin
			cmp1_sync_q <= {cmp1_sync_q[1:0], trip_async.cmp1};
			cmp2_sync_q <= {cmp2_sync_q[1:0], trip_async.cmp2};
			int_sync_q  <= {int_sync_q[1:0], trip_async.int_pin};
			if (cmp1_sync_q[1] == cmp1_sync_q[2]) begin
				cmp1_f_q <= cmp1_sync_q[2];
			end
			if (cmp2_sync_q[1] == cmp2_sync_q[2]) begin
				cmp2_f_q <= cmp2_sync_q[2];
			end
			if (int_sync_q[1] == int_sync_q[2]) begin
				int_f_q <= int_sync_q[2];
			end
		end
	end

	// comparator levels sampled on the timer1 edge when sync is on
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cmp1_trip_q <= 1'b0;
			cmp2_trip_q <= 1'b0;
		end else if (timer1_sync) begin
			cmp1_trip_q <= cmp1_f_q;
			cmp2_trip_q <= cmp2_f_q;
		end
	end

	assign cmp1_trip = channel_q[pwm_ctrl_pkg::CH_CSYNC_BIT] ? cmp1_trip_q : cmp1_f_q;
	assign cmp2_trip = channel_q[pwm_ctrl_pkg::CH_CSYNC_BIT] ? cmp2_trip_q : cmp2_f_q;

	// source select bits: [0] cmp1, [1] cmp2, [2] int pin low; zero disables
	always_comb begin
		trip = (shutdown_ctl_q[pwm_ctrl_pkg::SD_SRC_LO] && cmp1_trip) ||
		       (shutdown_ctl_q[pwm_ctrl_pkg::SD_SRC_LO + 1] && cmp2_trip) ||
		       (shutdown_ctl_q[pwm_ctrl_pkg::SD_SRC_HI] && !int_f_q);
	end

	// ------------------------------------------------------------
	// shutdown control and status
	// ------------------------------------------------------------
	assign auto_clear = shutdown_status && !trip && restart_dly_q[pwm_ctrl_pkg::RESTART_BIT];
	assign sd_rise    = trip && !shutdown_status;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shutdown_ctl_q <= pwm_ctrl_pkg::RST_SHUTDOWN;
		end else begin
			if (wr_en && wb_adr_i == pwm_ctrl_pkg::OFS_SHUTDOWN) begin
				// software may clear the status or force a shutdown
				shutdown_ctl_q <= wb_dat_i[7:0];
			end
			if (auto_clear) begin
				shutdown_ctl_q[pwm_ctrl_pkg::SD_STATUS_BIT] <= 1'b0;
			end
			// a live trip always wins over a clear
			if (trip) begin
				shutdown_ctl_q[pwm_ctrl_pkg::SD_STATUS_BIT] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// timebase and steering update
	// ------------------------------------------------------------
	always_comb begin
		case (ch5_timebase_select)
			pwm_ctrl_pkg::TB_TIMER2: begin
				pwm_sel    = timer_pwm[0];
				period_sel = timer_period_start[0];
			end
			pwm_ctrl_pkg::TB_TIMER4: begin
				pwm_sel    = timer_pwm[1];
				period_sel = timer_period_start[1];
			end
			pwm_ctrl_pkg::TB_TIMER6: begin
				pwm_sel    = timer_pwm[2];
				period_sel = timer_period_start[2];
			end
			default: begin
				// reserved code: no timebase, output idles
				pwm_sel    = 1'b0;
				period_sel = 1'b0;
			end
		endcase
	end

	assign steer_apply = (steer_live_q != steer_shadow_q[3:0]) &&
	                     (steer_shadow_q[pwm_ctrl_pkg::STEER_SYNC_BIT] ? period_sel : cyc_en);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			steer_live_q <= pwm_ctrl_pkg::RST_STEERING[3:0];
		end else if (steer_apply) begin
			steer_live_q <= steer_shadow_q[3:0];
		end
	end

	// ------------------------------------------------------------
	// dead band for the half-bridge pair
	// ------------------------------------------------------------
	deadband_delay u_db_a (
		.clk_sys (clk_sys),
		.srst    (srst),
		.cyc_en  (cyc_en),
		.delay   (restart_dly_q[pwm_ctrl_pkg::DELAY_HI:0]),
		.din     (pwm_sel),
		.dout    (db_a)
	);

	deadband_delay u_db_b (
		.clk_sys (clk_sys),
		.srst    (srst),
		.cyc_en  (cyc_en),
		.delay   (restart_dly_q[pwm_ctrl_pkg::DELAY_HI:0]),
		.din     (!pwm_sel),
		.dout    (db_b)
	);

	// ------------------------------------------------------------
	// output steering and shutdown override
	// ------------------------------------------------------------
	assign out_cfg    = channel_q[pwm_ctrl_pkg::CH_CFG_HI:pwm_ctrl_pkg::CH_CFG_LO];
	assign pwm_mode   = channel_q[pwm_ctrl_pkg::CH_MODE_HI -: 2] == pwm_ctrl_pkg::MODE_PWM_HI;
	assign steer_ok   = pwm_mode && out_cfg == pwm_ctrl_pkg::CFG_SINGLE;
	assign pol_ac_low = channel_q[1];
	assign pol_bd_low = channel_q[0];

	always_comb begin
		drv_out = port_out;
		drv_oe  = port_oe;
		if (steer_ok) begin
			for (int i = 0; i < 4; i++) begin
				if (steer_live_q[i]) begin
					drv_out[i] = polar(pwm_sel, (i == 0 || i == 2) ? pol_ac_low : pol_bd_low);
					drv_oe[i]  = 1'b1;
				end
			end
		end else if (pwm_mode) begin
			case (out_cfg)
				pwm_ctrl_pkg::CFG_HALF: begin
					drv_out[0] = polar(db_a, pol_ac_low);
					drv_out[1] = polar(db_b, pol_bd_low);
					drv_oe[1:0] = 2'h3;
				end
				pwm_ctrl_pkg::CFG_FULL_FWD: begin
					drv_out = {polar(pwm_sel, pol_bd_low), polar(1'b0, pol_ac_low),
					           polar(1'b0, pol_bd_low), polar(1'b1, pol_ac_low)};
					drv_oe  = 4'hf;
				end
				pwm_ctrl_pkg::CFG_FULL_REV: begin
					drv_out = {polar(1'b0, pol_bd_low), polar(1'b1, pol_ac_low),
					           polar(pwm_sel, pol_bd_low), polar(1'b0, pol_ac_low)};
					drv_oe  = 4'hf;
				end
				default: begin
					drv_out = port_out;
					drv_oe  = port_oe;
				end
			endcase
		end
		// shutdown overrides the waveform on all four pins in pwm mode
		if (pwm_mode && shutdown_status) begin
			{drv_oe[0], drv_out[0]} = safe_drive(shutdown_ctl_q[pwm_ctrl_pkg::SD_AC_HI:pwm_ctrl_pkg::SD_AC_LO]);
			{drv_oe[2], drv_out[2]} = safe_drive(shutdown_ctl_q[pwm_ctrl_pkg::SD_AC_HI:pwm_ctrl_pkg::SD_AC_LO]);
			{drv_oe[1], drv_out[1]} = safe_drive(shutdown_ctl_q[pwm_ctrl_pkg::SD_BD_HI:pwm_ctrl_pkg::SD_BD_LO]);
			{drv_oe[3], drv_out[3]} = safe_drive(shutdown_ctl_q[pwm_ctrl_pkg::SD_BD_HI:pwm_ctrl_pkg::SD_BD_LO]);
		end
	end

	// registered pins: one clock behind the waveform, no glitches
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pwm_pins.out <= 4'h0;
			pwm_pins.oe  <= 4'h0;
		end else begin
			pwm_pins.out <= drv_out;
			pwm_pins.oe  <= drv_oe;
		end
	end

	// ------------------------------------------------------------
	// interrupt status, write one to clear, set wins
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_status_q <= pwm_ctrl_pkg::RST_IRQ;
		end else begin
			if (wr_en && wb_adr_i == pwm_ctrl_pkg::OFS_IRQ_STATUS) begin
				irq_status_q <= irq_status_q & ~wb_dat_i[2:0];
			end
			if (sd_rise) begin
				irq_status_q[pwm_ctrl_pkg::IRQ_SHUT_BIT] <= 1'b1;
			end
			if (auto_clear) begin
				irq_status_q[pwm_ctrl_pkg::IRQ_RESTART_BIT] <= 1'b1;
			end
			if (steer_apply) begin
				irq_status_q[pwm_ctrl_pkg::IRQ_STEER_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

endmodule

// File: tb/power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model (
	input  wire pwm_ctrl_pkg::pin_bus_t pins,
	output logic [3:0]                  gate_on
);
	// a floating pin is held off by the gate pull-down
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gate_on[i] = pins.oe[i] ? pins.out[i] : 1'h0;
		end
	end
endmodule

// File: tb/pwm_shutdown_steering_ctrl_properties.sv
`timescale 1ns/10ps
module pwm_ctrl_checker (
	input wire logic                   clk_sys,
	input wire logic                   srst,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_we_i,
	input wire logic [7:0]             wb_adr_i,
	input wire logic [3:0]             wb_sel_i,
	input wire logic [31:0]            wb_dat_i,
	input wire logic [31:0]            wb_dat_o,
	input wire logic                   wb_ack_o,
	input wire pwm_ctrl_pkg::trip_in_t trip_async,
	input wire logic [3:0]             port_out,
	input wire logic [3:0]             port_oe,
	input wire pwm_ctrl_pkg::pin_bus_t pwm_pins,
	input wire logic                   irq
);
	// ------------------------------------------------------------
	// config mirror and settle counters
	// ------------------------------------------------------------
	logic [7:0] ch_q;
	logic [6:0] sd_q;
	logic [2:0] mask_q;
	logic [3:0] trip_cnt_q;
	logic [3:0] age_q;
	logic       wr;
	logic       trip;
	logic       shut;
	assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o;
	assign trip = (sd_q[4] & trip_async.cmp1) | (sd_q[5] & trip_async.cmp2) | (sd_q[6] & ~trip_async.int_pin);
	// margin of 8 covers the trip synchroniser plus the pin register
	assign shut = (trip_cnt_q >= 4'h8) & (age_q >= 4'h8) & (ch_q[3:2] == 2'h3);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ch_q   <= 8'h00;
			sd_q   <= 7'h00;
			mask_q <= 3'h0;
		end else if (wr) begin
			if (wb_adr_i == pwm_ctrl_pkg::OFS_CHANNEL) ch_q <= wb_dat_i[7:0];
			if (wb_adr_i == pwm_ctrl_pkg::OFS_SHUTDOWN) sd_q <= wb_dat_i[6:0];
			if (wb_adr_i == pwm_ctrl_pkg::OFS_IRQ_MASK) mask_q <= wb_dat_i[2:0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst || (wr && (wb_adr_i == pwm_ctrl_pkg::OFS_SHUTDOWN || wb_adr_i == pwm_ctrl_pkg::OFS_CHANNEL)))
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (srst || !trip || ch_q[4])
			trip_cnt_q <= 4'h0;
		else if (trip_cnt_q != 4'hf)
			trip_cnt_q <= trip_cnt_q + 4'h1;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_mask_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == pwm_ctrl_pkg::OFS_IRQ_MASK
		|-> wb_dat_o == {29'h0, mask_q}) else $error("mask read differs from last write");
	a_chan_readback: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == pwm_ctrl_pkg::OFS_CHANNEL |-> wb_dat_o == {24'h0, ch_q})
		else $error("channel read differs from last write");
	a_port_follow: assert property (
		!$past(srst) && $past(ch_q[3:2]) != 2'h3 |-> pwm_pins == {$past(port_out), $past(port_oe)})
		else $error("pins not under port control outside pwm mode");
	a_safe_pair_ac: assert property (shut |-> pwm_pins.oe[0] == !sd_q[3] && pwm_pins.oe[2] == !sd_q[3]
		&& (sd_q[3] || (pwm_pins.out[0] == sd_q[2] && pwm_pins.out[2] == sd_q[2])))
		else $error("pair a c not in safe state during trip");
	a_safe_pair_bd: assert property (shut |-> pwm_pins.oe[1] == !sd_q[1] && pwm_pins.oe[3] == !sd_q[1]
		&& (sd_q[1] || (pwm_pins.out[1] == sd_q[0] && pwm_pins.out[3] == sd_q[0])))
		else $error("pair b d not in safe state during trip");
	a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 && $past(mask_q, 2) == 3'h0 |-> !irq)
		else $error("irq high with all sources masked");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !wb_ack_o && !irq && pwm_pins == 8'h00)
		else $error("outputs active after reset");
	c_trip_seen: cover property (shut);
	c_irq_seen: cover property (irq);
	c_steer_write: cover property (wr && wb_adr_i == pwm_ctrl_pkg::OFS_STEERING);
endmodule
bind pwm_shutdown_steering_ctrl pwm_ctrl_checker pwm_ctrl_checker_inst (.clk_sys(clk_sys), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trip_async(trip_async),
	.port_out(port_out), .port_oe(port_oe), .pwm_pins(pwm_pins), .irq(irq));

// File: tb/pwm_shutdown_steering_ctrl_tb.sv
`timescale 1ns/10ps
module pwm_shutdown_steering_ctrl_tb;
	logic                   clk_sys = 1'h0;
	logic                   srst = 1'h1;
	logic                   wb_cyc_i = 1'h0;
	logic                   wb_stb_i = 1'h0;
	logic                   wb_we_i = 1'h0;
	logic [7:0]             wb_adr_i = 8'h00;
	logic [3:0]             wb_sel_i = 4'hf;
	logic [31:0]            wb_dat_i = 32'h0;
	logic [31:0]            wb_dat_o;
	logic                   wb_ack_o;
	logic [2:0]             timer_pwm = 3'h0;
	logic [2:0]             timer_period_start = 3'h0;
	logic                   timer1_sync = 1'h0;
	pwm_ctrl_pkg::trip_in_t trip_async = 3'h1;
	logic [3:0]             port_out = 4'h0;
	logic [3:0]             port_oe = 4'h0;
	pwm_ctrl_pkg::pin_bus_t pwm_pins;
	logic                   irq;
	logic [3:0]             gate_on;
	logic [31:0]            rd;
	logic [3:0]             sf;
	logic [2:0]             t;
	logic [1:0]             m;
	logic                   p;
	logic                   rs;
	int                     miscompares = 0;
	int                     tests_run = 0;
	int                     n;

	always #5 clk_sys = ~clk_sys;

	pwm_shutdown_steering_ctrl pwm_shutdown_steering_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_pwm(timer_pwm),
		.timer_period_start(timer_period_start), .timer1_sync(timer1_sync), .trip_async(trip_async),
		.port_out(port_out), .port_oe(port_oe), .pwm_pins(pwm_pins), .irq(irq));
	power_stage_model power_stage_model_inst (.pins(pwm_pins), .gate_on(gate_on));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// request held until ack is seen at a rising edge, then released
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
		@(posedge clk_sys);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h000000, dat};
		// no cycle budget here: a missing ack is left to the watchdog
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		xfer(1'h1, adr, dat);
	endtask
	task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
		xfer(1'h0, adr, 8'h00);
		chk(rd, {24'h000000, exp});
	endtask
	// expected {gate, oe} with every pin steered and driving pwm high
	function automatic logic [7:0] gate(input logic h, input logic [3:0] f);
		logic [1:0] st;
		gate = 8'hff;
		for (int i = 0; i < 4; i++) begin
			st = (i % 2 == 1) ? f[1:0] : f[3:2];
			if (h) begin
				gate[i + 4] = ~st[1] & st[0];
				gate[i] = ~st[1];
			end
		end
	endfunction
	task automatic end_sim;
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		end_sim();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		void'($urandom(98));
		cyc(16);
		srst <= 1'h0;
		rdchk(pwm_ctrl_pkg::OFS_TIMER_SEL, pwm_ctrl_pkg::RST_TIMER_SEL);
		rdchk(pwm_ctrl_pkg::OFS_SHUTDOWN, pwm_ctrl_pkg::RST_SHUTDOWN);
		rdchk(pwm_ctrl_pkg::OFS_STEERING, pwm_ctrl_pkg::RST_STEERING);
		rdchk(pwm_ctrl_pkg::OFS_CHANNEL, pwm_ctrl_pkg::RST_CHANNEL);
		rdchk(pwm_ctrl_pkg::OFS_IRQ_MASK, {5'h00, pwm_ctrl_pkg::RST_IRQ});
		wr(8'h1c, 8'hff);
		rdchk(8'h1c, 8'h00);
		wr(pwm_ctrl_pkg::OFS_TIMER_SEL, 8'hfe);
		rdchk(pwm_ctrl_pkg::OFS_TIMER_SEL, 8'h02);
		wr(pwm_ctrl_pkg::OFS_STEERING, 8'hef);
		rdchk(pwm_ctrl_pkg::OFS_STEERING, 8'h0f);
		for (int c = 0; c < 4; c++) begin
			for (int v = 0; v < 2; v++) begin
				m = (c == 3) ? 2'h0 : 2'($urandom);
				p = (c == 3) ? 1'h0 : 1'(v);
				wr(pwm_ctrl_pkg::OFS_TIMER_SEL, 8'(c));
				wr(pwm_ctrl_pkg::OFS_CHANNEL, {6'h03, m});
				timer_pwm <= (v == 1) ? 3'(1 << c) : ~3'(1 << c);
				cyc(4);
				chk({24'h0, pwm_pins}, {24'h0, {2{p ^ m[0], p ^ m[1]}}, 4'hf});
			end
		end
		port_out <= 4'($urandom);
		port_oe <= 4'($urandom);
		timer_pwm <= 3'h1;
		wr(pwm_ctrl_pkg::OFS_TIMER_SEL, 8'h00);
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'h0c);
		wr(pwm_ctrl_pkg::OFS_STEERING, 8'h15);
		cyc(8);
		chk({24'h0, pwm_pins}, 32'h000000ff);
		timer_period_start <= 3'h1;
		cyc(1);
		timer_period_start <= 3'h0;
		cyc(4);
		chk({24'h0, pwm_pins}, {24'h0, 4'h5 | port_out, 4'h5 | port_oe});
		wr(pwm_ctrl_pkg::OFS_STEERING, 8'h0a);
		cyc(6);
		chk({24'h0, pwm_pins}, {24'h0, 4'ha | port_out, 4'ha | port_oe});
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'h8c);
		wr(pwm_ctrl_pkg::OFS_RESTART_DLY, 8'h03);
		timer_pwm <= 3'h0;
		cyc(30);
		chk({24'h0, pwm_pins}, {24'h0, port_out[3:2], 2'h2, port_oe[3:2], 2'h3});
		timer_pwm <= 3'h1;
		n = 0;
		while (pwm_pins.out[0] !== 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= 9 && n <= 18), 32'h1);
		chk({30'h0, pwm_pins.out[1:0]}, 32'h1);
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'h4c);
		cyc(2);
		chk({24'h0, pwm_pins}, 32'h0000009f);
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'hce);
		cyc(2);
		chk({24'h0, pwm_pins}, 32'h0000003f);
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'h0c);
		wr(pwm_ctrl_pkg::OFS_STEERING, 8'h0f);
		wr(pwm_ctrl_pkg::OFS_IRQ_MASK, 8'h01);
		rdchk(pwm_ctrl_pkg::OFS_IRQ_MASK, 8'h01);
		for (int s = 0; s < 16; s++) begin
			sf = 4'($urandom);
			t = 3'($urandom % 7 + 1);
			rs = 1'(s / 8);
			p = |(3'(s) & t);
			wr(pwm_ctrl_pkg::OFS_RESTART_DLY, {rs, 7'h00});
			wr(pwm_ctrl_pkg::OFS_SHUTDOWN, {1'h0, 3'(s), sf});
			trip_async <= {t[0], t[1], ~t[2]};
			cyc(10);
			rdchk(pwm_ctrl_pkg::OFS_SHUTDOWN, {p, 3'(s), sf});
			chk({24'h0, gate_on, pwm_pins.oe}, {24'h0, gate(p, sf)});
			chk({31'h0, irq}, {31'h0, p});
			wr(pwm_ctrl_pkg::OFS_IRQ_MASK, 8'h00);
			cyc(3);
			chk({31'h0, irq}, 32'h0);
			wr(pwm_ctrl_pkg::OFS_IRQ_MASK, 8'h01);
			trip_async <= 3'h1;
			cyc(10);
			rdchk(pwm_ctrl_pkg::OFS_SHUTDOWN, {p & ~rs, 3'(s), sf});
			wr(pwm_ctrl_pkg::OFS_SHUTDOWN, {1'h0, 3'(s), sf});
			wr(pwm_ctrl_pkg::OFS_IRQ_STATUS, 8'h07);
			cyc(4);
			chk({24'h0, gate_on, pwm_pins.oe}, 32'h000000ff);
		end
		wr(pwm_ctrl_pkg::OFS_CHANNEL, 8'h1c);
		wr(pwm_ctrl_pkg::OFS_SHUTDOWN, 8'h10);
		trip_async <= 3'h5;
		cyc(10);
		rdchk(pwm_ctrl_pkg::OFS_SHUTDOWN, 8'h10);
		timer1_sync <= 1'h1;
		cyc(1);
		timer1_sync <= 1'h0;
		cyc(8);
		rdchk(pwm_ctrl_pkg::OFS_SHUTDOWN, 8'h90);
		end_sim();
	end
endmodule
